// ==== design/phy_ctrl_map.svh ====
// Register offsets, field positions, reset values and timing counts of the PHY control bank
`ifndef PHY_CTRL_MAP_SVH
`define PHY_CTRL_MAP_SVH

`define OFS_BASIC_MODE_CONTROL 5'h00
`define OFS_BASIC_MODE_STATUS 5'h01
`define OFS_PHY_IDENTIFIER_HIGH 5'h02
`define OFS_PHY_IDENTIFIER_LOW 5'h03
`define OFS_NEGOTIATION_ADVERTISE 5'h04
`define OFS_PARTNER_ABILITY 5'h05
`define OFS_NEGOTIATION_EXPANSION 5'h06
`define OFS_NEXT_PAGE_TRANSMIT 5'h07
`define OFS_NEXT_PAGE_RECEIVE 5'h08
`define OFS_GIGABIT_CONTROL 5'h09
`define OFS_GIGABIT_STATUS 5'h0A
`define OFS_GIGABIT_EXTENDED_STATUS 5'h0F

`define BIT_SOFT_RESET 15
`define BIT_LOOPBACK 14
`define BIT_SPEED_LOW 13
`define BIT_NEGOTIATION_ENABLE 12
`define BIT_POWER_DOWN 11
`define BIT_ISOLATE 10
`define BIT_NEGOTIATION_RESTART 9
`define BIT_DUPLEX 8
`define BIT_SPEED_HIGH 6

`define CONTROL_RESET_VALUE 16'h1140
`define CONTROL_WRITE_MASK 16'hFFC0
`define STATUS_RESET_VALUE 16'h7949
`define STATUS_NEG_DONE_BIT 5
`define RW_RESET_VALUE 16'h0000

// Reset process length and negotiation start latency
`define RESET_TIME_NS 1000
`define RESET_CYCLES ((`RESET_TIME_NS + 19) / 20)
`define NEG_START_CYCLES 4

`endif

// ==== design/phy_ctrl_pkg.sv ====
// Types shared by the PHY control register bank
package phy_ctrl_pkg;

  typedef enum logic [1:0] {
    SPEED_10 = 2'b00,
    SPEED_100 = 2'b01,
    SPEED_1000 = 2'b10,
    SPEED_RSVD = 2'b11
  } link_speed_t;

  typedef struct packed {
    logic loopback;
    logic power_down;
    logic isolate;
    logic forced_mode;
    link_speed_t speed;
    logic full_duplex;
  } link_ctrl_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : phy_ctrl_pkg

// ==== design/phy_basic_mode_control_regs.sv ====
// Management register bank and basic mode control logic of the PHY
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "phy_ctrl_map.svh"

module phy_basic_mode_control_regs #(
  parameter int RESET_CYCLES = `RESET_CYCLES,
  parameter int NEG_START_CYCLES = `NEG_START_CYCLES,
  // Arbitrary identifier values, not taken from any part
  parameter logic [15:0] ID_HIGH = 16'h0A5A,
  parameter logic [15:0] ID_LOW = 16'h5A50
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [7:0] mii_tx_data,
  input wire logic mii_tx_en,
  input wire logic [7:0] line_rx_data,
  input wire logic line_rx_dv,
  input wire logic neg_done,
  output logic [7:0] mii_rx_data,
  output logic mii_rx_dv,
  output logic [7:0] line_tx_data,
  output logic line_tx_en,
  output logic neg_running,
  output logic neg_start,
  output phy_ctrl_pkg::link_ctrl_t link_ctrl
);
  import phy_ctrl_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESET = 2'b01,
    ST_START = 2'b10,
    ST_RUN = 2'b11
  } neg_state_t;

  localparam int CNT_W = 16;
  localparam int NUM_RW = 6;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] rw_index(input logic [4:0] a);
    if (a == `OFS_NEGOTIATION_ADVERTISE) rw_index = 3'd0;
    else if (a == `OFS_PARTNER_ABILITY) rw_index = 3'd1;
    else if (a == `OFS_NEGOTIATION_EXPANSION) rw_index = 3'd2;
    else if (a == `OFS_NEXT_PAGE_TRANSMIT) rw_index = 3'd3;
    else if (a == `OFS_NEXT_PAGE_RECEIVE) rw_index = 3'd4;
    else if (a == `OFS_GIGABIT_CONTROL) rw_index = 3'd5;
    else rw_index = 3'd7;
  endfunction : rw_index

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] rw_q [NUM_RW];
  logic [15:0] rw_d [NUM_RW];
  logic neg_done_q, neg_done_d;
  neg_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [15:0] rdata_d;
  reg_req_t req;
  logic ctrl_wr;
  logic soft_reset;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign ctrl_wr = req.wr && (req.addr == `OFS_BASIC_MODE_CONTROL);
  assign soft_reset = ctrl_wr && req.wdata[`BIT_SOFT_RESET];

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    neg_start = 1'b0;
    ctrl_d = ctrl_q;
    neg_done_d = neg_done_q;
    for (int i = 0; i < NUM_RW; i++)
      rw_d[i] = rw_q[i];
    if (soft_reset)
    begin
      // Everything returns to defaults; reset bit held until mode entry
      ctrl_d = `CONTROL_RESET_VALUE;
      ctrl_d[`BIT_SOFT_RESET] = 1'b1;
      neg_done_d = 1'b0;
      for (int i = 0; i < NUM_RW; i++)
        rw_d[i] = `RW_RESET_VALUE;
      st_d = ST_RESET;
      cnt_d = CNT_W'(RESET_CYCLES);
    end
    else
    begin
      if (ctrl_wr)
      begin
        // Read-only low bits keep their value; the reset bit is set-only
        ctrl_d = (req.wdata & `CONTROL_WRITE_MASK) | (ctrl_q & ~`CONTROL_WRITE_MASK);
        ctrl_d[`BIT_SOFT_RESET] = ctrl_q[`BIT_SOFT_RESET];
        // Restart ignored when negotiation disabled; clear by software allowed
        ctrl_d[`BIT_NEGOTIATION_RESTART] = req.wdata[`BIT_NEGOTIATION_RESTART]
          && req.wdata[`BIT_NEGOTIATION_ENABLE];
      end
      else if (req.wr && rw_index(req.addr) != 3'd7)
        rw_d[rw_index(req.addr)] = req.wdata;
      if (neg_done && st_q == ST_RUN)
        neg_done_d = 1'b1;
      case (st_q)
        ST_RESET:
        begin
          if (cnt_q > 1)
            cnt_d = cnt_q - 1'b1;
          else if (ctrl_q[`BIT_NEGOTIATION_ENABLE])
          begin
            st_d = ST_START;
            cnt_d = CNT_W'(NEG_START_CYCLES);
          end
          else
          begin
            // Entering forced mode completes the reset
            ctrl_d[`BIT_SOFT_RESET] = 1'b0;
            st_d = ST_IDLE;
          end
        end
        ST_START:
        begin
          if (!ctrl_d[`BIT_NEGOTIATION_ENABLE])
          begin
            // A reset still pending ends as forced mode is entered
            ctrl_d[`BIT_SOFT_RESET] = 1'b0;
            st_d = ST_IDLE;
          end
          else if (cnt_q > 1)
            cnt_d = cnt_q - 1'b1;
          else if (ctrl_wr && req.wdata[`BIT_NEGOTIATION_RESTART])
            // A restart written as the start fires wins and reloads the delay
            cnt_d = CNT_W'(NEG_START_CYCLES);
          else
          begin
            // Negotiation has begun: both self-clearing bits drop
            neg_start = 1'b1;
            ctrl_d[`BIT_SOFT_RESET] = 1'b0;
            ctrl_d[`BIT_NEGOTIATION_RESTART] = 1'b0;
            neg_done_d = 1'b0;
            st_d = ST_RUN;
          end
        end
        default:
        begin
          if (!ctrl_d[`BIT_NEGOTIATION_ENABLE])
            st_d = ST_IDLE;
          else if (ctrl_d[`BIT_NEGOTIATION_RESTART] && !ctrl_q[`BIT_NEGOTIATION_RESTART])
          begin
            st_d = ST_START;
            cnt_d = CNT_W'(NEG_START_CYCLES);
          end
          else if (st_q == ST_IDLE && ctrl_d[`BIT_NEGOTIATION_ENABLE])
          begin
            st_d = ST_START;
            cnt_d = CNT_W'(NEG_START_CYCLES);
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_q <= `CONTROL_RESET_VALUE;
      neg_done_q <= 1'b0;
      st_q <= ST_IDLE;
      cnt_q <= '0;
      for (int i = 0; i < NUM_RW; i++)
        rw_q[i] <= `RW_RESET_VALUE;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      neg_done_q <= neg_done_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      for (int i = 0; i < NUM_RW; i++)
        rw_q[i] <= rw_d[i];
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata_d = 16'h0000;
    if (req.addr == `OFS_BASIC_MODE_CONTROL)
      rdata_d = ctrl_q;
    else if (req.addr == `OFS_BASIC_MODE_STATUS)
    begin
      rdata_d = `STATUS_RESET_VALUE;
      rdata_d[`STATUS_NEG_DONE_BIT] = neg_done_q;
    end
    else if (req.addr == `OFS_PHY_IDENTIFIER_HIGH)
      rdata_d = ID_HIGH;
    else if (req.addr == `OFS_PHY_IDENTIFIER_LOW)
      rdata_d = ID_LOW;
    else if (rw_index(req.addr) != 3'd7)
      rdata_d = rw_q[rw_index(req.addr)];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (req.rd)
      rdata <= rdata_d;
  end

  // ---------------------------------------------------------------
  // Link control and data path
  // ---------------------------------------------------------------
  link_ctrl_t lc;
  always_comb
  begin
    lc.loopback = ctrl_q[`BIT_LOOPBACK];
    lc.power_down = ctrl_q[`BIT_POWER_DOWN];
    lc.isolate = ctrl_q[`BIT_ISOLATE];
    lc.forced_mode = !ctrl_q[`BIT_NEGOTIATION_ENABLE];
    // Forced fields only matter with negotiation off
    lc.speed = lc.forced_mode ?
      link_speed_t'({ctrl_q[`BIT_SPEED_HIGH], ctrl_q[`BIT_SPEED_LOW]}) : SPEED_1000;
    lc.full_duplex = lc.forced_mode ? ctrl_q[`BIT_DUPLEX] : 1'b1;
  end

  logic dp_off;
  assign dp_off = lc.power_down || lc.isolate;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      link_ctrl <= '0;
      mii_rx_data <= 8'h00;
      mii_rx_dv <= 1'b0;
      line_tx_data <= 8'h00;
      line_tx_en <= 1'b0;
    end
    else
    begin
      link_ctrl <= lc;
      if (dp_off)
      begin
        // Management keeps working; the data path goes quiet and neg_running drops
        mii_rx_data <= 8'h00;
        mii_rx_dv <= 1'b0;
        line_tx_data <= 8'h00;
        line_tx_en <= 1'b0;
      end
      else if (lc.loopback)
      begin
        mii_rx_data <= mii_tx_data;
        mii_rx_dv <= mii_tx_en;
        line_tx_data <= 8'h00;
        line_tx_en <= 1'b0;
      end
      else
      begin
        mii_rx_data <= line_rx_data;
        mii_rx_dv <= line_rx_dv;
        line_tx_data <= mii_tx_data;
        line_tx_en <= mii_tx_en;
      end
    end
  end

  assign neg_running = (st_q == ST_RUN) && !dp_off;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  reset_sets_defaults_a: assert property (@(posedge sys_clk) disable iff (rst)
    soft_reset |=> (ctrl_q == (`CONTROL_RESET_VALUE | 16'h8000)))
    else $error("soft reset did not restore control defaults");

  reset_bit_holds_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ctrl_q[15] && st_q == ST_RESET && cnt_q > 1) |=> ctrl_q[15])
    else $error("reset bit cleared early");

  reset_done_forced_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == ST_RESET && cnt_q <= 1 && !ctrl_q[12] && !wr) |=> !ctrl_q[15])
    else $error("reset bit not cleared in forced mode");

  loopback_path_a: assert property (@(posedge sys_clk) disable iff (rst)
    (lc.loopback && !dp_off) |=> (mii_rx_data == $past(mii_tx_data)))
    else $error("loopback data not returned");

  forced_speed_a: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl_q[12] |=> (link_ctrl.speed == {$past(ctrl_q[6]), $past(ctrl_q[13])}))
    else $error("forced speed wrong");

  power_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_q[11] |=> (!mii_rx_dv && !line_tx_en))
    else $error("data path active in power down");

  restart_ignored_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ctrl_wr && !soft_reset && !wdata[12]) |=> !ctrl_q[9])
    else $error("restart taken with negotiation disabled");

  restart_clears_a: assert property (@(posedge sys_clk) disable iff (rst)
    neg_start |=> (!ctrl_q[9] && st_q == ST_RUN))
    else $error("restart bit not cleared on start");

  isolate_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_q[10] |=> (!mii_rx_dv && !line_tx_en))
    else $error("data path active while isolated");

  isolate_mgmt_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr == `OFS_BASIC_MODE_CONTROL && ctrl_q[10]) |=> rdata[10])
    else $error("management read lost during isolation");

  negotiated_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!rst && ctrl_q[12]) |=> (link_ctrl.speed == SPEED_1000 && link_ctrl.full_duplex
      && !link_ctrl.forced_mode))
    else $error("forced fields leaked into negotiated mode");

  forced_duplex_a: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl_q[12] |=> (link_ctrl.full_duplex == $past(ctrl_q[8])))
    else $error("forced duplex wrong");

  normal_path_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!rst && !lc.loopback && !dp_off) |=> (mii_rx_data == $past(line_rx_data)
      && line_tx_data == $past(mii_tx_data)))
    else $error("normal data path broken");

  loopback_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    lc.loopback |=> !line_tx_en)
    else $error("line transmit active in loopback");

  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr > `OFS_GIGABIT_STATUS && addr != `OFS_GIGABIT_EXTENDED_STATUS)
      |=> (rdata == 16'h0000))
    else $error("reserved location read nonzero");

  low_bits_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_wr |=> (ctrl_q[5:0] == 6'h00))
    else $error("read-only control bits written");

  reset_clears_state_a: assert property (@(posedge sys_clk) disable iff (rst)
    soft_reset |=> (st_q == ST_RESET && !neg_done_q))
    else $error("soft reset did not restart state");

  restart_starts_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ctrl_wr && !soft_reset && wdata[9] && wdata[12] && st_q != ST_RESET)
      |=> (st_q == ST_START))
    else $error("restart write did not start negotiation");

  restart_cleared_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == ST_RUN && ctrl_wr && !soft_reset && wdata[12] && !wdata[9])
      |=> (st_q == ST_RUN))
    else $error("clearing restart disturbed negotiation");

  start_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    neg_start |=> !neg_start)
    else $error("start pulse longer than one cycle");

endmodule : phy_basic_mode_control_regs

// ==== tb/neg_engine_model.sv ====
// Behavioural negotiation engine on the far side of the PHY control bank
`timescale 1ns/1ps

module neg_engine_model #(
  parameter int DONE_DELAY = 40
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic neg_start,
  input wire logic neg_running,
  output logic neg_done
);
  int cnt_q;

  // Completion drops at once when negotiation stops or begins again
  always_ff @(posedge sys_clk)
  begin
    if (rst || neg_start || !neg_running)
    begin
      cnt_q <= 0;
      neg_done <= 1'b0;
    end
    else if (cnt_q == DONE_DELAY)
      neg_done <= 1'b1;
    else
      cnt_q <= cnt_q + 1;
  end
endmodule : neg_engine_model

// ==== tb/testbench.sv ====
// Self-checking bench of the PHY control register bank
`timescale 1ns/1ps
`include "phy_ctrl_map.svh"

module testbench;
  import phy_ctrl_pkg::*;

  // Arbitrary identifier values
  localparam logic [15:0] ID_H = 16'h1234;
  localparam logic [15:0] ID_L = 16'h5678;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] mii_tx_data = 8'h00;
  logic mii_tx_en = 1'b0;
  logic [7:0] line_rx_data = 8'h00;
  logic line_rx_dv = 1'b0;
  logic [15:0] rdata;
  logic [7:0] mii_rx_data, line_tx_data;
  logic mii_rx_dv, line_tx_en, neg_running, neg_start, neg_done;
  logic rd_q = 1'b0;
  link_ctrl_t link_ctrl;
  logic [15:0] rdq[$];
  logic [7:0] rxq[$], txq[$];
  int mismatches = 0;
  int num_checks = 0;
  int starts = 0;
  int seed = 2;
  int mode = 0;

  phy_basic_mode_control_regs #(.RESET_CYCLES(2), .NEG_START_CYCLES(3), .ID_HIGH(ID_H),
    .ID_LOW(ID_L)) uut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .mii_tx_data(mii_tx_data), .mii_tx_en(mii_tx_en),
    .line_rx_data(line_rx_data), .line_rx_dv(line_rx_dv), .neg_done(neg_done),
    .mii_rx_data(mii_rx_data), .mii_rx_dv(mii_rx_dv), .line_tx_data(line_tx_data),
    .line_tx_en(line_tx_en), .neg_running(neg_running), .neg_start(neg_start),
    .link_ctrl(link_ctrl));

  neg_engine_model #(.DONE_DELAY(40)) partner (.sys_clk(sys_clk), .rst(rst),
    .neg_start(neg_start), .neg_running(neg_running), .neg_done(neg_done));

  always #10 sys_clk = ~sys_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // --------------------------------------------------------------
  // Bus tasks: each access raises its own strobe and lowers the other; idle lowers both
  // --------------------------------------------------------------
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    rdq.push_back(e);
    @(posedge sys_clk);
  endtask : rd_reg

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // Mode 0 passes both ways, 1 loops transmit back, 2 stays silent
  task automatic send(input int n);
    logic [7:0] t, r;
    repeat (n)
    begin
      t = 8'($random(seed));
      r = 8'($random(seed));
      mii_tx_data <= t;
      mii_tx_en <= 1'b1;
      line_rx_data <= r;
      line_rx_dv <= 1'b1;
      if (mode == 0) rxq.push_back(r);
      if (mode == 0) txq.push_back(t);
      if (mode == 1) rxq.push_back(t);
      @(posedge sys_clk);
    end
    mii_tx_en <= 1'b0;
    line_rx_dv <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(16'(rxq.size() + txq.size()), 16'h0000);
  endtask : send

  task automatic wait_start(input int n);
    for (int i = 0; i < n && starts == 0; i++) @(posedge sys_clk);
    if (starts == 0)
    begin
      check(16'h0000, 16'h0001);
      end_sim();
    end
  endtask : wait_start

  // Outputs are sampled before the edge updates land
  always @(posedge sys_clk)
  begin
    rd_q <= rd;
    if (neg_start === 1'b1) starts++;
    if (rd_q) check(rdata, rdq.pop_front());
    if (mii_rx_dv !== 1'b0)
      check({8'h00, mii_rx_data}, rxq.size() > 0 ? {8'h00, rxq.pop_front()} : 16'hFFFF);
    if (line_tx_en !== 1'b0)
      check({8'h00, line_tx_data}, txq.size() > 0 ? {8'h00, txq.pop_front()} : 16'hFFFF);
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_reg(`OFS_BASIC_MODE_CONTROL, `CONTROL_RESET_VALUE);
    wr_reg(`OFS_BASIC_MODE_STATUS, 16'hFFFF);
    rd_reg(`OFS_BASIC_MODE_STATUS, `STATUS_RESET_VALUE);
    for (int a = 11; a < 32; a++)
    begin
      if (a < 15 || a > 24) wr_reg(5'(a), 16'hFFFF);
      if (a < 15 || a > 24) rd_reg(5'(a), 16'h0000);
    end
    wr_reg(`OFS_PHY_IDENTIFIER_HIGH, 16'hFFFF);
    rd_reg(`OFS_PHY_IDENTIFIER_HIGH, ID_H);
    rd_reg(`OFS_PHY_IDENTIFIER_LOW, ID_L);
    wr_reg(`OFS_NEGOTIATION_ADVERTISE, 16'hA5A5);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h017F);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h0140);
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(`OFS_BASIC_MODE_CONTROL, {2'b00, s[0], 4'h0, s[0], 1'b0, s[1], 6'h00});
      idle(2);
      if (s < 3) check(16'(link_ctrl.speed), 16'(s));
      check(16'({link_ctrl.forced_mode, link_ctrl.full_duplex}), 16'({1'b1, s[0]}));
    end
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h3000);
    idle(2);
    check(16'({link_ctrl.speed, link_ctrl.full_duplex}), 16'h0005);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h4140);
    mode = 1;
    idle(2);
    check(16'(link_ctrl.loopback), 16'h0001);
    send(8);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h0140);
    mode = 0;
    idle(2);
    send(8);
    mode = 2;
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h0940);
    idle(2);
    send(6);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h0940);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h0540);
    idle(2);
    check(16'(link_ctrl.isolate), 16'h0001);
    send(6);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h0540);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h1800);
    idle(5);
    check(16'({neg_running, link_ctrl.power_down}), 16'h0001);
    mode = 0;
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h0000);
    starts = 0;
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h0200);
    idle(10);
    check(16'(starts), 16'h0000);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h0000);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h1200);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h1200);
    idle(1);
    wait_start(20);
    idle(2);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h1000);
    starts = 0;
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h1000);
    idle(5);
    check(16'({neg_running, 8'(starts)}), 16'h0100);
    idle(45);
    rd_reg(`OFS_BASIC_MODE_STATUS, `STATUS_RESET_VALUE | 16'h0020);
    // Negotiation switched off while the reset counts, then while the start is pending
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h8000);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h0000);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h8000);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h0000);
    rd_reg(`OFS_BASIC_MODE_STATUS, `STATUS_RESET_VALUE);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h8000);
    idle(2);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h0000);
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h0000);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h4140);
    wr_reg(`OFS_BASIC_MODE_CONTROL, 16'h8000);
    starts = 0;
    rd_reg(`OFS_BASIC_MODE_CONTROL, 16'h9140);
    idle(1);
    wait_start(100);
    idle(2);
    rd_reg(`OFS_BASIC_MODE_CONTROL, `CONTROL_RESET_VALUE);
    rd_reg(`OFS_NEGOTIATION_ADVERTISE, `RW_RESET_VALUE);
    idle(3);
    check(16'({link_ctrl.loopback, link_ctrl.forced_mode}), 16'h0000);
    end_sim();
  end
endmodule : testbench
